//--- hw/crcbr_host.sv
// Purpose: APB-driven controller that operates the CRC device registers.
// Assumes: Device read data is valid the cycle after the read strobe.
// Notes:   Data bytes queue in a FIFO before they reach the device.

// Synchronous FIFO with valid/ready on both sides.
module crcbr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("crcbr_fifo: DEPTH must be a power of two, at least 2.");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage.
  logic [AW-1:0]    wptr_reg;     // Next slot to write.
  logic [AW-1:0]    rptr_reg;     // Oldest slot.
  logic [AW:0]      count_reg;    // Words held.
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rptr_reg];

  // Storage write; no reset needed for the data itself.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      wptr_reg  <= wptr_reg + AW'(push);
      rptr_reg  <= rptr_reg + AW'(pop);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module crcbr_host
  import crcbr_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  crcbr_if.ctl             sfr
);

  // Auxiliary register value that selects a port destination.
  function automatic logic [7:0] aux_of(input crcbr_sel_t s);
    return {2'b00, s, 4'h0};
  endfunction

  crcbr_hst_t  st_reg;      // Sequencer state.
  crcbr_seq_t  seq_reg;     // Sequence being run.
  logic [2:0]  idx_reg;     // Step within the sequence.
  logic [15:0] seed_reg;    // Seed to load.
  logic [15:0] start_reg;   // Sweep start address.
  logic [6:0]  bound_reg;   // Sweep boundary.
  logic [16:0] raw_reg;     // Raw access: read flag, offset, data.
  logic [15:0] result_reg;  // Last result read back.
  logic [7:0]  rawrd_reg;   // Last raw read data.
  logic [7:0]  addr_reg;    // Bus offset, registered.
  logic [7:0]  wdata_reg;   // Bus write data, registered.
  logic        wr_reg;      // Bus write strobe, registered.
  logic        rd_reg;      // Bus read strobe, registered.
  logic        last_reg;    // Step just issued ends the sequence.
  crcbr_op_t   op;          // Current step.
  logic        acc;         // APB access phase.
  logic        ctrl_ok;     // Command may be taken.
  logic        fifo_in_rdy;
  logic        fifo_vld;
  logic [7:0]  fifo_data;
  logic        fifo_pop;

  assign acc      = psel && penable;
  assign ctrl_ok  = (st_reg == CRCBR_H_IDLE) && !fifo_vld && !sfr.busy;
  assign fifo_pop = (st_reg == CRCBR_H_ISSUE) && (seq_reg == CRCBR_SEQ_DATA);

  // Data writes stall while the FIFO is full; commands stall while busy.
  always_comb begin
    pready = 1'b1;
    if (pwrite && paddr == `CRCBR_APB_DATA) begin
      pready = fifo_in_rdy;
    end else if (pwrite && paddr == `CRCBR_APB_CTRL) begin
      pready = ctrl_ok;
    end
  end
  assign pslverr = 1'b0;

  crcbr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (acc && pwrite && paddr == `CRCBR_APB_DATA),
    .in_ready  (fifo_in_rdy),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Step table of every sequence; the seed goes in before data and the seed, result
  // and sweep sequences leave the select at the data input, so later data writes need no re-select.
  always_comb begin
    op = '{rd: 1'b0, addr: `CRCBR_OFS_AUX, data: aux_of(CRCBR_SEL_DATA), last: 1'b1};
    unique case (seq_reg)
      CRCBR_SEQ_DATA: op = '{1'b0, `CRCBR_OFS_PORT, fifo_data, 1'b1};
      CRCBR_SEQ_SEED, CRCBR_SEQ_RESULT: begin
        unique case (idx_reg)
          3'h0: op = '{1'b0, `CRCBR_OFS_AUX, aux_of(CRCBR_SEL_LO), 1'b0};
          3'h1: op = '{seq_reg == CRCBR_SEQ_RESULT, `CRCBR_OFS_PORT, seed_reg[7:0], 1'b0};
          3'h2: op = '{1'b0, `CRCBR_OFS_AUX, aux_of(CRCBR_SEL_HI), 1'b0};
          3'h3: op = '{seq_reg == CRCBR_SEQ_RESULT, `CRCBR_OFS_PORT, seed_reg[15:8], 1'b0};
          default: ;
        endcase
      end
      CRCBR_SEQ_AUTO: begin
        unique case (idx_reg)
          3'h0: op = '{1'b0, `CRCBR_OFS_AUX, aux_of(CRCBR_SEL_DATA), 1'b0};
          3'h1: op = '{1'b0, `CRCBR_OFS_FADR_H, start_reg[15:8], 1'b0};
          3'h2: op = '{1'b0, `CRCBR_OFS_FADR_L, start_reg[7:0], 1'b0};
          3'h3: op = '{1'b0, `CRCBR_OFS_BOUND, {1'b0, bound_reg}, 1'b0};
          3'h4: op = '{1'b0, `CRCBR_OFS_MODE, `CRCBR_MODE_AUTO, 1'b0};
          3'h5: op = '{1'b0, `CRCBR_OFS_CMD, `CRCBR_KEY_FIRST, 1'b0};
          default: op = '{1'b0, `CRCBR_OFS_CMD, `CRCBR_KEY_SECOND, 1'b1};
        endcase
      end
      default: op = '{raw_reg[16], raw_reg[15:8], raw_reg[7:0], 1'b1};
    endcase
  end

  // Configuration registers written over APB.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seed_reg  <= 16'h0000;
      start_reg <= 16'h0000;
      bound_reg <= 7'h00;
      raw_reg   <= 17'h00000;
    end else if (acc && pwrite) begin
      unique case (paddr)
        `CRCBR_APB_SEED:  seed_reg  <= pwdata[15:0];
        `CRCBR_APB_START: start_reg <= pwdata[15:0];
        `CRCBR_APB_BOUND: bound_reg <= pwdata[6:0];
        `CRCBR_APB_RAW:   raw_reg   <= pwdata[16:0];
        default: ;
      endcase
    end
  end

  // Sequencer: compute a step, drive it for one cycle, then collect.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= CRCBR_H_IDLE;
      seq_reg <= CRCBR_SEQ_DATA;
      idx_reg <= 3'h0;
    end else begin
      unique case (st_reg)
        CRCBR_H_IDLE: begin
          idx_reg <= 3'h0;
          if (acc && pwrite && paddr == `CRCBR_APB_CTRL && ctrl_ok) begin
            // Unknown codes are ignored.
            if (pwdata[2:0] >= `CRCBR_CMD_SEED && pwdata[2:0] <= `CRCBR_CMD_RAW) begin
              seq_reg <= crcbr_seq_t'(pwdata[2:0]);
              st_reg  <= CRCBR_H_ISSUE;
            end
          end else if (fifo_vld && !sfr.busy) begin
            // Data is held back during a sweep; the device would drop it.
            seq_reg <= CRCBR_SEQ_DATA;
            st_reg  <= CRCBR_H_ISSUE;
          end
        end
        CRCBR_H_ISSUE: st_reg <= CRCBR_H_BUS;
        CRCBR_H_BUS:   st_reg <= CRCBR_H_TAIL;
        CRCBR_H_TAIL: begin
          idx_reg <= idx_reg + 3'h1;
          st_reg  <= last_reg ? CRCBR_H_IDLE : CRCBR_H_ISSUE;
        end
      endcase
    end
  end

  // Bus outputs come from flip-flops loaded in the issue cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      wr_reg <= (st_reg == CRCBR_H_ISSUE) && !op.rd;
      rd_reg <= (st_reg == CRCBR_H_ISSUE) && op.rd;
      if (st_reg == CRCBR_H_ISSUE) begin
        addr_reg  <= op.addr;
        wdata_reg <= op.data;
        last_reg  <= op.last;
      end
    end
  end

  assign sfr.addr  = addr_reg;
  assign sfr.wdata = wdata_reg;
  assign sfr.wr    = wr_reg;
  assign sfr.rd    = rd_reg;

  // Read data is collected in the cycle after the strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 16'h0000;
      rawrd_reg  <= 8'h00;
    end else if (st_reg == CRCBR_H_TAIL) begin
      if (seq_reg == CRCBR_SEQ_RESULT && idx_reg == 3'h1) begin
        result_reg[7:0] <= sfr.rdata;
      end
      if (seq_reg == CRCBR_SEQ_RESULT && idx_reg == 3'h3) begin
        result_reg[15:8] <= sfr.rdata;
      end
      if (seq_reg == CRCBR_SEQ_RAW && rd_reg == 1'b0 && raw_reg[16]) begin
        rawrd_reg <= sfr.rdata;
      end
    end
  end

  // APB read multiplexer; unmapped offsets read zero.
  always_comb begin
    unique case (paddr)
      `CRCBR_APB_SEED:   prdata = {16'h0000, seed_reg};
      `CRCBR_APB_START:  prdata = {16'h0000, start_reg};
      `CRCBR_APB_BOUND:  prdata = {25'h0000000, bound_reg};
      `CRCBR_APB_RAW:    prdata = {15'h0000, raw_reg};
      `CRCBR_APB_STATUS: prdata = {result_reg, 13'h0000, !fifo_vld, sfr.busy,
                                   st_reg != CRCBR_H_IDLE};
      `CRCBR_APB_RAWRD:  prdata = {24'h000000, rawrd_reg};
      default:           prdata = 32'h00000000;
    endcase
  end

endmodule

//--- shared/crcbr_params.svh
// Purpose: Offsets, codes, reset values and field positions of the CRC block.
// Assumes: 8-bit special-function register bus, APB-facing controller.
// Notes:   Included by the package, through which both ends see it.
`ifndef CRCBR_PARAMS_SVH
`define CRCBR_PARAMS_SVH
// Device register offsets.
`define CRCBR_OFS_BITREV   8'h96
`define CRCBR_OFS_AUX      8'ha2
`define CRCBR_OFS_PORT     8'hb6
`define CRCBR_OFS_MODE     8'he5
`define CRCBR_OFS_FADR_H   8'hc1
`define CRCBR_OFS_FADR_L   8'hc2
`define CRCBR_OFS_BOUND    8'hc3
`define CRCBR_OFS_CMD      8'hc4
// Field positions of the auxiliary control register.
`define CRCBR_AUX_SEL_LSB  4
`define CRCBR_AUX_PTR_BIT  0
// Reset values.
`define CRCBR_RST_BYTE     8'h00
`define CRCBR_RST_CRC      16'h0000
// Checksum generator and the auto-read codes.
`define CRCBR_POLY         16'h1021
`define CRCBR_MODE_AUTO    8'h80
`define CRCBR_KEY_FIRST    8'h46
`define CRCBR_KEY_SECOND   8'hb9
`define CRCBR_END_LOW_ONES 9'h1ff
// Controller APB offsets.
`define CRCBR_APB_CTRL     8'h00
`define CRCBR_APB_SEED     8'h04
`define CRCBR_APB_DATA     8'h08
`define CRCBR_APB_START    8'h0c
`define CRCBR_APB_BOUND    8'h10
`define CRCBR_APB_RAW      8'h14
`define CRCBR_APB_STATUS   8'h18
`define CRCBR_APB_RAWRD    8'h1c
// Controller command codes.
`define CRCBR_CMD_SEED     3'h1
`define CRCBR_CMD_RESULT   3'h2
`define CRCBR_CMD_AUTO     3'h3
`define CRCBR_CMD_RAW      3'h4
`endif

//--- shared/crcbr_pkg.sv
// Purpose: Types shared by both ends of the CRC block.
// Assumes: Constants come from the params header.
// Notes:   State codes are one-hot.
`include "crcbr_params.svh"
package crcbr_pkg;
  // Data port select codes.
  typedef enum logic [1:0] {
    CRCBR_SEL_LO   = 2'b00,
    CRCBR_SEL_HI   = 2'b01,
    CRCBR_SEL_RSVD = 2'b10,
    CRCBR_SEL_DATA = 2'b11
  } crcbr_sel_t;
  // Flash auto-read engine states.
  typedef enum logic [2:0] {
    CRCBR_AR_IDLE = 3'b001,
    CRCBR_AR_REQ  = 3'b010,
    CRCBR_AR_WAIT = 3'b100
  } crcbr_ar_t;
  // Controller sequencer states.
  typedef enum logic [3:0] {
    CRCBR_H_IDLE  = 4'b0001,
    CRCBR_H_ISSUE = 4'b0010,
    CRCBR_H_BUS   = 4'b0100,
    CRCBR_H_TAIL  = 4'b1000
  } crcbr_hst_t;
  // Access sequences the controller can run.
  typedef enum logic [2:0] {
    CRCBR_SEQ_DATA   = 3'h0,
    CRCBR_SEQ_SEED   = 3'h1,
    CRCBR_SEQ_RESULT = 3'h2,
    CRCBR_SEQ_AUTO   = 3'h3,
    CRCBR_SEQ_RAW    = 3'h4
  } crcbr_seq_t;
  // One register access of a sequence.
  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
    logic       last;
  } crcbr_op_t;
endpackage

//--- shared/crcbr_if.sv
// Purpose: Register bus between the controller and the CRC device.
// Assumes: One clock; rdata is valid the cycle after a read strobe.
// Notes:   Strobes are one-cycle pulses.
interface crcbr_if;
  logic [7:0] addr;   // Register offset.
  logic       wr;     // Write strobe.
  logic       rd;     // Read strobe.
  logic [7:0] wdata;  // Write data.
  logic [7:0] rdata;  // Read data, registered.
  logic       busy;   // Auto-read sweep in progress.
  modport dev (input addr, wr, rd, wdata, output rdata, busy);
  modport ctl (output addr, wr, rd, wdata, input rdata, busy);
endinterface

//--- hw/crcbr_device.sv
// Purpose: Byte-serial CRC-16 engine with bit reversal and flash auto-read.
// Assumes: Flash answers a request with flash_rvalid some cycles later.
// Notes:   Registers are reached through the crcbr_if device modport.
module crcbr_device
  import crcbr_pkg::*;
#(
  parameter int FLASH_AW = 16
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  crcbr_if.dev                     sfr,
  output logic                     flash_req,
  output logic [FLASH_AW-1:0]      flash_addr,
  input  wire logic [7:0]          flash_rdata,
  input  wire logic                flash_rvalid
);

  // The end address is seven boundary bits over nine ones.
  if (FLASH_AW != 16) begin : g_aw_check
    $error("crcbr_device: FLASH_AW must be 16.");
  end

  // Fold one byte into the remainder, most significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0]  din);
    logic [15:0] r;
    r = crc ^ {din, 8'h00};
    for (int i = 0; i < 8; i++) begin
      // Shift out the top bit and subtract the generator when it was set.
      r = r[15] ? ({r[14:0], 1'b0} ^ `CRCBR_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // Mirror the bit order of a byte.
  function automatic logic [7:0] mirror(input logic [7:0] b);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = b[7-i];
    end
    return m;
  endfunction

  logic [7:0]          bitrev_reg;   // Byte stored already mirrored.
  crcbr_sel_t          sel_reg;      // Data port select field.
  logic                ptr_sel_reg;  // Data pointer select bit.
  logic [15:0]         crc_reg;      // Running remainder, also the seed.
  logic [7:0]          mode_reg;     // Flash mode field.
  logic [7:0]          fadr_h_reg;   // Flash start address, high byte.
  logic [7:0]          fadr_l_reg;   // Flash start address, low byte.
  logic [6:0]          bound_reg;    // Application boundary.
  logic                armed_reg;    // First unlock key seen.
  crcbr_ar_t           ar_reg;       // Auto-read engine state.
  logic [FLASH_AW-1:0] ar_addr_reg;  // Address of the byte in flight.
  logic [FLASH_AW-1:0] ar_end_reg;   // Last address of the sweep.
  logic [7:0]          rdata_reg;    // Registered read data.

  // Write strobes per register.
  logic wr_bitrev;
  logic wr_aux;
  logic wr_port;
  logic wr_mode;
  logic wr_cmd;
  logic start;      // Second key accepted, sweep begins.
  logic ar_byte;    // Flash byte arrives this cycle.

  assign wr_bitrev = sfr.wr && (sfr.addr == `CRCBR_OFS_BITREV);
  assign wr_aux    = sfr.wr && (sfr.addr == `CRCBR_OFS_AUX);
  assign wr_port   = sfr.wr && (sfr.addr == `CRCBR_OFS_PORT);
  assign wr_mode   = sfr.wr && (sfr.addr == `CRCBR_OFS_MODE);
  assign wr_cmd    = sfr.wr && (sfr.addr == `CRCBR_OFS_CMD);
  assign ar_byte   = (ar_reg == CRCBR_AR_WAIT) && flash_rvalid;

  // The second key only counts if it is the very next write and the
  // flash mode already selects the automatic read.
  assign start = wr_cmd && armed_reg && (sfr.wdata == `CRCBR_KEY_SECOND)
              && (mode_reg == `CRCBR_MODE_AUTO) && (ar_reg == CRCBR_AR_IDLE);

  // Bit-reverse register: mirrored on the way in, so reads are plain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitrev_reg <= `CRCBR_RST_BYTE;
    end else if (wr_bitrev) begin
      bitrev_reg <= mirror(sfr.wdata);
    end
  end

  // Auxiliary control: only the select field and the pointer bit store.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg     <= CRCBR_SEL_LO;
      ptr_sel_reg <= 1'b0;
    end else if (wr_aux) begin
      sel_reg     <= crcbr_sel_t'(sfr.wdata[`CRCBR_AUX_SEL_LSB +: 2]);
      ptr_sel_reg <= sfr.wdata[`CRCBR_AUX_PTR_BIT];
    end
  end

  // Remainder. A flash byte wins over a port write in the same cycle;
  // port data writes are dropped during a sweep so no byte is mixed in.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_reg <= `CRCBR_RST_CRC;
    end else if (ar_byte) begin
      crc_reg <= crc_byte(crc_reg, flash_rdata);
    end else if (wr_port) begin
      unique case (sel_reg)
        // Seed bytes load the remainder directly.
        CRCBR_SEL_LO:   crc_reg[7:0]  <= sfr.wdata;
        CRCBR_SEL_HI:   crc_reg[15:8] <= sfr.wdata;
        // Data input: one byte per write.
        CRCBR_SEL_DATA: begin
          if (ar_reg == CRCBR_AR_IDLE) begin
            crc_reg <= crc_byte(crc_reg, sfr.wdata);
          end
        end
        // Reserved destination: the write has no effect.
        CRCBR_SEL_RSVD: crc_reg <= crc_reg;
      endcase
    end
  end

  // Flash mode and sweep address registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= `CRCBR_RST_BYTE;
      fadr_h_reg <= `CRCBR_RST_BYTE;
      fadr_l_reg <= `CRCBR_RST_BYTE;
      bound_reg  <= 7'h00;
    end else if (sfr.wr) begin
      if (wr_mode) begin
        mode_reg <= sfr.wdata;
      end
      if (sfr.addr == `CRCBR_OFS_FADR_H) begin
        fadr_h_reg <= sfr.wdata;
      end
      if (sfr.addr == `CRCBR_OFS_FADR_L) begin
        fadr_l_reg <= sfr.wdata;
      end
      if (sfr.addr == `CRCBR_OFS_BOUND) begin
        bound_reg <= sfr.wdata[6:0];
      end
    end
  end

  // Unlock key tracking: any write other than the first key disarms,
  // which makes the two keys have to follow each other directly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (sfr.wr) begin
      armed_reg <= wr_cmd && (sfr.wdata == `CRCBR_KEY_FIRST);
    end
  end

  // Auto-read engine: request, wait for the byte, step until the end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ar_reg      <= CRCBR_AR_IDLE;
      ar_addr_reg <= '0;
      ar_end_reg  <= '0;
    end else begin
      unique case (ar_reg)
        CRCBR_AR_IDLE: begin
          if (start) begin
            ar_addr_reg <= {fadr_h_reg, fadr_l_reg};
            ar_end_reg  <= {bound_reg, `CRCBR_END_LOW_ONES};
            ar_reg      <= CRCBR_AR_REQ;
          end
        end
        // One request pulse per byte.
        CRCBR_AR_REQ: begin
          ar_reg <= CRCBR_AR_WAIT;
        end
        // The end address is inclusive; a start above the end wraps.
        CRCBR_AR_WAIT: begin
          if (flash_rvalid) begin
            if (ar_addr_reg == ar_end_reg) begin
              ar_reg <= CRCBR_AR_IDLE;
            end else begin
              ar_addr_reg <= ar_addr_reg + 1'b1;
              ar_reg      <= CRCBR_AR_REQ;
            end
          end
        end
      endcase
    end
  end

  assign flash_req  = (ar_reg == CRCBR_AR_REQ);
  assign flash_addr = ar_addr_reg;
  assign sfr.busy   = (ar_reg != CRCBR_AR_IDLE);

  // Read multiplexer; reserved selects and unmapped offsets read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= `CRCBR_RST_BYTE;
    end else if (sfr.rd) begin
      unique case (sfr.addr)
        `CRCBR_OFS_BITREV: rdata_reg <= bitrev_reg;
        `CRCBR_OFS_AUX:    rdata_reg <= {2'b00, sel_reg, 3'b000, ptr_sel_reg};
        `CRCBR_OFS_PORT: begin
          unique case (sel_reg)
            CRCBR_SEL_LO:   rdata_reg <= crc_reg[7:0];
            CRCBR_SEL_HI:   rdata_reg <= crc_reg[15:8];
            CRCBR_SEL_RSVD: rdata_reg <= 8'h00;
            CRCBR_SEL_DATA: rdata_reg <= 8'h00;
          endcase
        end
        `CRCBR_OFS_MODE:   rdata_reg <= mode_reg;
        `CRCBR_OFS_FADR_H: rdata_reg <= fadr_h_reg;
        `CRCBR_OFS_FADR_L: rdata_reg <= fadr_l_reg;
        `CRCBR_OFS_BOUND:  rdata_reg <= {1'b0, bound_reg};
        default:           rdata_reg <= 8'h00;
      endcase
    end
  end

  assign sfr.rdata = rdata_reg;

endmodule

//--- dv/crcbr_props.sv
// Purpose: Checks on the register bus between controller and CRC device.
// Assumes: One clock domain and an active-low reset.
// Notes:   Shadow flops track the aux, bit-reverse and key writes.
module crcbr_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       busy
);
  logic [7:0] aux_reg; // Last aux write.
  logic [7:0] rev_reg; // Last bit-reverse write.
  logic [7:0] mir;     // Mirror of it.
  logic       key_reg; // Last write was the first key.
  assign mir = {<<{rev_reg}};
  // Shadow only writes, so reads are judged against what was stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_reg <= 8'h00;
      rev_reg <= 8'h00;
      key_reg <= 1'b0;
    end else if (wr) begin
      if (addr == 8'ha2) aux_reg <= wdata;
      if (addr == 8'h96) rev_reg <= wdata;
      key_reg <= (addr == 8'hc4) && (wdata == 8'h46);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_excl; !(wr && rd); endproperty
  a_excl: assert property (p_excl) else $error("read and write strobe together");
  property p_busy; $rose(busy) |-> $past(wr && addr == 8'hc4 && wdata == 8'hb9 && key_reg); endproperty
  a_busy: assert property (p_busy) else $error("sweep began without key pair");
  property p_key; wr && addr == 8'hc4 && wdata == 8'hb9 |-> key_reg; endproperty
  a_key: assert property (p_key) else $error("second key out of order");
  property p_sel; busy && wr && addr == 8'ha2 |-> wdata[5:4] == 2'b11; endproperty
  a_sel: assert property (p_sel) else $error("select moved during sweep");
  property p_rev; rd && addr == 8'h96 |=> rdata == mir; endproperty
  a_rev: assert property (p_rev) else $error("bit reverse read wrong");
  property p_aux; rd && addr == 8'ha2 |=> rdata == (aux_reg & 8'h31); endproperty
  a_aux: assert property (p_aux) else $error("aux read wrong");
  property p_rsvd; rd && addr == 8'hb6 && aux_reg[5] |=> rdata == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved port read not zero");
  property p_hold; !rd |=> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule

//--- dv/tb_crc16_with_bit_reverse.sv
// Purpose: Self-checking bench for the controller and device pair.
// Assumes: Flash answers each request one cycle later.
// Notes:   A flash byte is its address low byte xor 0x5a.
module tb_crc16_with_bit_reverse;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fval = 0;
  logic [7:0]  paddr = 8'h00, frd = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, freq;
  logic [15:0] faddr, crc, nxt = 16'h01f0;
  logic [39:0] rows [4] = '{40'h0000011021, 40'h0000809188, 40'hffffffff00, 40'h1234123400};
  int          mismatches = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  crcbr_if sfr_if ();
  crcbr_host #(.FIFO_DEPTH(16)) crcbr_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sfr(sfr_if));
  crcbr_device #(.FLASH_AW(16)) crcbr_device_inst (.pclk(pclk), .presetn(presetn), .sfr(sfr_if),
    .flash_req(freq), .flash_addr(faddr), .flash_rdata(frd), .flash_rvalid(fval));
  crcbr_props crcbr_props_inst (.pclk(pclk), .presetn(presetn), .addr(sfr_if.addr),
    .wr(sfr_if.wr), .rd(sfr_if.rd), .wdata(sfr_if.wdata), .rdata(sfr_if.rdata), .busy(sfr_if.busy));
  // Flash stand-in; it also checks the sweep address order.
  always @(posedge pclk) begin
    fval <= freq;
    frd <= faddr[7:0] ^ 8'h5a;
    if (freq === 1'b1) begin
      chk(faddr, nxt);
      nxt <= nxt + 16'h1;
    end
  end
  function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task complete_run;
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; read data lands in q.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 500);
    q = prdata;
    if (pready !== 1'b1) begin mismatches++; complete_run; end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Poll status until controller and device are both idle.
  task wt;
    int n;
    n = 0;
    do begin apb(1'b0, 8'h18, 32'h0); n++; end while (q[1:0] !== 2'b00 && n < 300);
    if (q[1:0] !== 2'b00) begin mismatches++; complete_run; end
  endtask
  task cmd(input logic [31:0] c); apb(1'b1, 8'h00, c); wt; endtask
  task seed(input logic [15:0] s); apb(1'b1, 8'h04, {16'h0, s}); cmd(32'h1); endtask
  task raw(input logic [16:0] v); apb(1'b1, 8'h14, {15'h0, v}); cmd(32'h4); apb(1'b0, 8'h1c, 32'h0); endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h4);
    seed(16'hffff);
    for (int i = 1; i < 10; i++) apb(1'b1, 8'h08, 32'h30 + i);
    cmd(32'h2);
    chk(q[31:16], 16'h29b1);
    for (int r = 0; r < 4; r++) begin
      seed(rows[r][39:24]);
      apb(1'b1, 8'h08, {24'h0, rows[r][23:16]});
      cmd(32'h2);
      chk(q[31:16], rows[r][15:0]);
    end
    raw({1'b0, 8'h96, 8'ha0});
    raw({1'b1, 8'h96, 8'h00});
    chk(q[7:0], 8'h05);
    raw({1'b0, 8'ha2, 8'h21});
    raw({1'b0, 8'hb6, 8'h55});
    raw({1'b1, 8'hb6, 8'h00});
    chk(q[7:0], 8'h00);
    raw({1'b1, 8'ha2, 8'h00});
    chk(q[7:0], 8'h21);
    cmd(32'h2);
    chk(q[31:16], 16'h3400);
    seed(16'h0000);
    apb(1'b1, 8'h0c, 32'h01f0);
    apb(1'b1, 8'h10, 32'h0);
    cmd(32'h3);
    cmd(32'h2);
    crc = 16'h0000;
    for (int a = 16'h01f0; a < 16'h0200; a++) crc = fold(crc, a[7:0] ^ 8'h5a);
    chk(q[31:16], crc);
    chk(nxt, 16'h0200);
    // A reset after the sweep must clear the result and leave both ends idle.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h4);
    complete_run;
  end
endmodule
